// ### bench/cpu_bus_model.sv
// CPU side model: programmed I/O strobes and identify cycles
module cpu_bus_model (
	input  wire logic        core_clk,
	output logic             io_execute_instruction,
	output logic      [10:0] io_addr,
	output logic      [15:0] io_wdata,
	output logic             identify_strobe
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus shows garbage, never the last value
	initial begin
		io_execute_instruction = 1'b0;
		io_addr = 11'h7FF;
		io_wdata = 16'hFFFF;
		identify_strobe = 1'b0;
	end

	// One access: strobe and qualifiers held over the taking edge
	task automatic bus_access(input logic [10:0] a, input logic [15:0] d);
		@(posedge core_clk);
		io_execute_instruction <= 1'b1;
		io_addr <= a;
		io_wdata <= d;
		@(posedge core_clk);
		io_execute_instruction <= 1'b0;
		io_addr <= ~a;
		io_wdata <= ~d;
	endtask

	// A rate change is always followed by a device clear
	task automatic set_rate(input logic [15:0] d);
		bus_access(11'h0C1, d);
		bus_access(11'h0C3, 16'h0010);
	endtask

	// Level code settles one cycle before the strobe rises
	task automatic ident(input logic [1:0] lvl, input int hold);
		@(posedge core_clk);
		io_addr <= {9'h000, lvl};
		@(posedge core_clk);
		identify_strobe <= 1'b1;
		repeat (hold) @(posedge core_clk);
		identify_strobe <= 1'b0;
		io_addr <= ~io_addr;
	endtask
endmodule // cpu_bus_model

// ### bench/tb.sv
// Self-checking bench of the terminal rate and interrupt logic
`include "term_map.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic                  core_clk = 1'b0;
	logic                  reset = 1'b1;
	logic                  clk_en = 1'b1;
	logic                  rx_char_ready = 1'b0;
	logic                  tx_buf_ready = 1'b0;
	logic            [6:0] ident_switch = 7'h6D;
	logic                  io_execute_instruction;
	logic           [10:0] io_addr;
	logic           [15:0] io_wdata;
	logic                  identify_strobe;
	logic           [15:0] io_rdata;
	logic                  io_rdata_valid;
	term_pkg::baud_t       rx_baud;
	term_pkg::baud_t       tx_baud;
	logic                  rx_rate_known;
	logic                  tx_rate_known;
	logic                  rate_load;
	logic                  dev_clear;
	logic                  rx_int_req;
	logic                  tx_int_req;
	logic                  reply;
	logic                  connect;
	logic            [7:0] ident_data;
	logic                  ident_data_oe;
	int                    mismatches = 0;
	int                    samples_checked = 0;

	// Rate rows: the code is the index, beside the baud it selects
	term_pkg::baud_t rates [16] = '{`TERM_B9600, `TERM_B4800, `TERM_B2400,
		`TERM_B1200, `TERM_BNONE, `TERM_BNONE, `TERM_BNONE, `TERM_BNONE,
		`TERM_B600, `TERM_B300, `TERM_B150, `TERM_B75, `TERM_B110,
		`TERM_B200, `TERM_B100, `TERM_B50};

	// 10 MHz core clock
	always #50 core_clk = ~core_clk;

	serial_term_rate_irq serial_term_rate_irq_i (
		.core_clk, .reset, .clk_en, .io_execute_instruction, .io_addr,
		.io_wdata, .rx_char_ready, .tx_buf_ready, .identify_strobe,
		.ident_switch, .io_rdata, .io_rdata_valid, .rx_baud, .tx_baud,
		.rx_rate_known, .tx_rate_known, .rate_load, .dev_clear,
		.rx_int_req, .tx_int_req, .reply, .connect, .ident_data,
		.ident_data_oe
	);

	cpu_bus_model cpu_bus_model_i (
		.core_clk, .io_execute_instruction, .io_addr, .io_wdata,
		.identify_strobe
	);

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", samples_checked,
			mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Bounded watch for a one-cycle pulse; a missing or an unexpected pulse is a mismatch
	task automatic seen_pulse(input string nm, input int sel,
		input logic exp);
		logic got;
		got = 1'b0;
		for (int i = 0; i < 4; i++) begin
			#1;
			if ((sel == 0 && rate_load === 1'b1) ||
				(sel == 1 && dev_clear === 1'b1) ||
				(sel == 2 && io_rdata_valid === 1'b1)) begin
				got = 1'b1;
			end
			@(posedge core_clk);
		end
		#1;
		check(nm, 16'(got), 16'(exp));
	endtask

	task automatic rd(input logic [10:0] a, input logic hit,
		input logic [15:0] d);
		cpu_bus_model_i.bus_access(a, 16'h0000);
		seen_pulse("rdata_valid", 2, hit);
		check("rdata", io_rdata, d);
	endtask

	// Answer shows after the take and holds while the strobe stays high
	task automatic ident_run(input logic [1:0] lvl, input logic ans);
		fork
			cpu_bus_model_i.ident(lvl, 6);
			begin
				repeat (4) @(posedge core_clk);
				rx_char_ready <= 1'b1;
				#1;
				check("reply", 16'(reply), 16'(ans));
				check("connect", 16'(connect), 16'(ans));
				check("oe", 16'(ident_data_oe), 16'(ans));
				check("code", 16'(ident_data),
					ans ? {9'h000, ident_switch} : 16'h0000);
				repeat (2) @(posedge core_clk);
				#1;
				check("reply_held", 16'(reply), 16'(ans));
			end
		join
		repeat (3) @(posedge core_clk);
		#1;
		check("reply_end", 16'(reply), 16'h0000);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		check("rst_oe", 16'(ident_data_oe), 16'h0000);
		check("rst_req", 16'({rx_int_req, tx_int_req}), 16'h0000);
		repeat (3) @(posedge core_clk);
		#1;
		check("rst_rx_baud", 16'(rx_baud), 16'(`TERM_B9600));
		$display("Test reset done");
		// Every code on one channel, its mirror on the other
		for (int i = 0; i < 16; i++) begin
			cpu_bus_model_i.set_rate({8'hA5, 4'(i), 4'(15 - i)});
			repeat (3) @(posedge core_clk);
			#1;
			check("tx_baud", 16'(tx_baud), 16'(rates[i]));
			check("rx_baud", 16'(rx_baud), 16'(rates[15 - i]));
			check("tx_known", 16'(tx_rate_known),
				16'(rates[i] !== `TERM_BNONE));
			check("rx_known", 16'(rx_rate_known),
				16'(rates[15 - i] !== `TERM_BNONE));
		end
		$display("Test rate table done");
		cpu_bus_model_i.bus_access(11'h0C1, 16'h000C);
		seen_pulse("rate_load", 0, 1'b1);
		cpu_bus_model_i.bus_access(11'h0C3, 16'h0010);
		check("rx_110", 16'(rx_baud), 16'(`TERM_B110));
		check("tx_9600", 16'(tx_baud), 16'(`TERM_B9600));
		cpu_bus_model_i.set_rate(16'h00CC);
		cpu_bus_model_i.bus_access(11'h0C3, 16'h0010);
		seen_pulse("dev_clear", 1, 1'b1);
		check("rx_kept", 16'(rx_baud), 16'(`TERM_B110));
		check("tx_kept", 16'(tx_baud), 16'(`TERM_B110));
		$display("Test rates and clear done");
		@(posedge core_clk);
		rx_char_ready <= 1'b1;
		tx_buf_ready <= 1'b1;
		cpu_bus_model_i.bus_access(11'h0C3, 16'h0001);
		cpu_bus_model_i.bus_access(11'h0C7, 16'h0001);
		rd(11'h0C2, 1'b1, 16'h0009);
		rd(11'h0C6, 1'b1, 16'h0009);
		rd(11'h0C4, 1'b1, 16'h0000);
		rd(11'h0D2, 1'b0, 16'h0000);
		check("reqs", 16'({rx_int_req, tx_int_req}), 16'h0003);
		@(posedge core_clk);
		rx_char_ready <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		check("rx_req_off", 16'(rx_int_req), 16'h0000);
		check("tx_req_on", 16'(tx_int_req), 16'h0001);
		@(posedge core_clk);
		rx_char_ready <= 1'b1;
		$display("Test registers done");
		ident_run(2'h2, 1'b1);
		check("rx_req_ack", 16'(rx_int_req), 16'h0000);
		check("tx_req_ack", 16'(tx_int_req), 16'h0001);
		rd(11'h0C2, 1'b1, 16'h0008);
		ident_run(2'h0, 1'b1);
		check("tx_req_cut", 16'(tx_int_req), 16'h0000);
		@(posedge core_clk);
		rx_char_ready <= 1'b0;
		cpu_bus_model_i.bus_access(11'h0C3, 16'h0001);
		ident_run(2'h2, 1'b0);
		check("rx_ie_kept", 16'(rx_int_req), 16'h0001);
		// Level codes 1 and 3 belong to neither channel
		ident_run(2'h1, 1'b0);
		ident_run(2'h3, 1'b0);
		check("rx_req_kept", 16'(rx_int_req), 16'h0001);
		$display("Test identify done");
		// Frozen clock enable: a rate write must not be taken
		@(posedge core_clk);
		clk_en <= 1'b0;
		cpu_bus_model_i.bus_access(11'h0C1, 16'h0033);
		seen_pulse("frozen_load", 0, 1'b0);
		check("frozen_rx", 16'(rx_baud), 16'(`TERM_B110));
		check("frozen_tx", 16'(tx_baud), 16'(`TERM_B110));
		@(posedge core_clk);
		clk_en <= 1'b1;
		cpu_bus_model_i.bus_access(11'h0C3, 16'h0010);
		seen_pulse("thawed_clear", 1, 1'b1);
		check("thawed_rx", 16'(rx_baud), 16'(`TERM_B110));
		$display("Test clock enable done");
		// Reset in mid-run drops enables and rates; ready stays up
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		check("mid_rst_req", 16'({rx_int_req, tx_int_req}), 16'h0000);
		check("mid_rst_baud", 16'(rx_baud), 16'h0000);
		@(posedge core_clk);
		#1;
		check("mid_rst_rx", 16'(rx_baud), 16'(`TERM_B9600));
		rd(11'h0C2, 1'b1, 16'h0008);
		$display("Test mid-run reset done");
		report_and_stop();
	end
endmodule // tb

// ### hw/rate_decode.sv
// Four-bit rate code to baud decoder
`include "term_map.svh"

module rate_decode (
	rate_if.dec rif
);

	// ****************************************************************
	// Code table; codes 4..7 are unassigned and give zero
	// ****************************************************************
	always_comb begin
		rif.known = 1'b1;
		case (rif.code)
			4'h0: rif.baud = `TERM_B9600;
			4'h1: rif.baud = `TERM_B4800;
			4'h2: rif.baud = `TERM_B2400;
			4'h3: rif.baud = `TERM_B1200;
			4'h8: rif.baud = `TERM_B600;
			4'h9: rif.baud = `TERM_B300;
			4'hD: rif.baud = `TERM_B200;
			4'hA: rif.baud = `TERM_B150;
			4'hC: rif.baud = `TERM_B110;
			4'hE: rif.baud = `TERM_B100;
			4'hB: rif.baud = `TERM_B75;
			4'hF: rif.baud = `TERM_B50;
			default: begin
				rif.baud  = `TERM_BNONE;
				rif.known = 1'b0;
			end
		endcase
	end

endmodule // rate_decode

// ### hw/rate_if.sv
// Carrier between a rate field and its decoder
interface rate_if;
	term_pkg::rate_code_t code;
	term_pkg::baud_t      baud;
	logic                 known;

	modport dec (input code, output baud, output known);
	modport user (output code, input baud, input known);
endinterface

// ### hw/serial_term_rate_irq.sv
// Rate select and interrupt/identify logic of the serial terminal card
`include "term_map.svh"

module serial_term_rate_irq #(
	parameter logic [10:0] DEV_BASE = `TERM_DEV_BASE
) (
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire logic                 clk_en,
	input  wire logic                 io_execute_instruction,
	input  wire logic [10:0]          io_addr,
	input  wire logic [15:0]          io_wdata,
	input  wire logic                 rx_char_ready,
	input  wire logic                 tx_buf_ready,
	input  wire logic                 identify_strobe,
	input  wire logic [6:0]           ident_switch,
	output logic      [15:0]          io_rdata,
	output logic                      io_rdata_valid,
	output term_pkg::baud_t           rx_baud,
	output term_pkg::baud_t           tx_baud,
	output logic                      rx_rate_known,
	output logic                      tx_rate_known,
	output logic                      rate_load,
	output logic                      dev_clear,
	output logic                      rx_int_req,
	output logic                      tx_int_req,
	output logic                      reply,
	output logic                      connect,
	output logic      [7:0]           ident_data,
	output logic                      ident_data_oe
);

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	// The group decode compares address bits 10..3 only
	if (DEV_BASE[2:0] != 3'h0) begin : g_base_check
		$error("DEV_BASE must be a multiple of eight");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0]          rate_r;
	logic                rx_ie_r;
	logic                tx_ie_r;
	term_pkg::id_state_t id_state_r;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire logic       dev_hit;
	wire logic [2:0] ofs;
	wire logic       wr_rate;
	wire logic       wr_rx_ctrl;
	wire logic       wr_tx_ctrl;
	wire logic       rd_rx_stat;
	wire logic       rd_tx_stat;
	wire logic       rd_any;

	assign dev_hit = io_execute_instruction &&
	                 (io_addr[10:3] == DEV_BASE[10:3]);
	assign ofs        = io_addr[2:0];
	assign wr_rate    = dev_hit && (ofs == `TERM_OFS_RATE);
	assign wr_rx_ctrl = dev_hit && (ofs == `TERM_OFS_RX_CTRL);
	assign wr_tx_ctrl = dev_hit && (ofs == `TERM_OFS_TX_CTRL);
	assign rd_rx_stat = dev_hit && (ofs == `TERM_OFS_RX_STAT);
	assign rd_tx_stat = dev_hit && (ofs == `TERM_OFS_TX_STAT);
	assign rd_any     = dev_hit && !wr_rate && !wr_rx_ctrl && !wr_tx_ctrl;

	// ****************************************************************
	// Requests and status words
	// ****************************************************************
	wire logic        rx_req;
	wire logic        tx_req;
	wire logic [15:0] rx_stat;
	wire logic [15:0] tx_stat;
	wire logic [15:0] rd_word;

	// Ready comes from the serial side, enable from software
	assign rx_req = rx_char_ready && rx_ie_r;
	assign tx_req = tx_buf_ready && tx_ie_r;
	assign rx_stat = (16'(rx_char_ready) << `TERM_STAT_RDY_BIT) |
	                 (16'(rx_ie_r) << `TERM_STAT_IE_BIT);
	assign tx_stat = (16'(tx_buf_ready) << `TERM_STAT_RDY_BIT) |
	                 (16'(tx_ie_r) << `TERM_STAT_IE_BIT);
	// Data register reads at offsets 0 and 4 live elsewhere: zero here
	assign rd_word = rd_rx_stat ? rx_stat :
	                 rd_tx_stat ? tx_stat : 16'h0000;

	// ****************************************************************
	// Identify decode
	// ****************************************************************
	wire logic       id_start;
	wire logic       sel_rx;
	wire logic       sel_tx;
	wire logic       hit_req;
	wire logic       clr_rx;
	wire logic       clr_tx;
	wire logic [7:0] ident_code;

	// Level code is already stable when the strobe rises
	assign sel_rx   = (io_addr[1:0] == `TERM_LVL_RX);
	assign sel_tx   = (io_addr[1:0] == `TERM_LVL_TX);
	assign id_start = (id_state_r == term_pkg::ID_IDLE) && identify_strobe;
	// Sample the request line itself, as the processor sees it
	assign hit_req  = (sel_rx && rx_int_req) ||
	                  (sel_tx && tx_int_req);
	assign clr_rx   = id_start && sel_rx && rx_int_req;
	assign clr_tx   = id_start && sel_tx && tx_int_req;
	// Open switch reads one; one code serves both levels
	assign ident_code = {1'b0, ident_switch};

	// ****************************************************************
	// Next values of enables and rates
	// ****************************************************************
	logic       rx_ie_nxt;
	logic       tx_ie_nxt;
	logic [7:0] rate_nxt;

	// A control write in the identify edge wins over the clear, so
	// software that re-enables at that moment is not overruled
	assign rx_ie_nxt = wr_rx_ctrl ? io_wdata[`TERM_CTRL_IE_BIT] :
	                   clr_rx     ? 1'b0 : rx_ie_r;
	assign tx_ie_nxt = wr_tx_ctrl ? io_wdata[`TERM_CTRL_IE_BIT] :
	                   clr_tx     ? 1'b0 : tx_ie_r;
	// Device clear does not touch the rate register
	assign rate_nxt  = wr_rate ? io_wdata[7:0] : rate_r;

	// ****************************************************************
	// Rate decoders, one per channel
	// ****************************************************************
	term_pkg::baud_t baud_w [2];
	logic            known_w [2];

	for (genvar g = 0; g < 2; g++) begin : g_rate
		rate_if rif ();
		// Channel 0 receives from bits 3..0, channel 1 sends from 7..4
		assign rif.code = rate_r[(g == 0 ? `TERM_RX_CODE_LSB :
		                          `TERM_TX_CODE_LSB) +: 4];
		assign baud_w[g]  = rif.baud;
		assign known_w[g] = rif.known;
		rate_decode u_dec (
			.rif (rif.dec)
		);
	end

	// ****************************************************************
	// Register file
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rate_r  <= `TERM_RATE_RST;
			rx_ie_r <= 1'b0;
			tx_ie_r <= 1'b0;
		end else if (clk_en) begin
			rate_r  <= rate_nxt;
			rx_ie_r <= rx_ie_nxt;
			tx_ie_r <= tx_ie_nxt;
		end
	end

	// ****************************************************************
	// Bus side outputs
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			io_rdata       <= 16'h0000;
			io_rdata_valid <= 1'b0;
			rate_load      <= 1'b0;
			dev_clear      <= 1'b0;
		end else if (clk_en) begin
			io_rdata_valid <= rd_any;
			if (rd_any) begin
				io_rdata <= rd_word;
			end
			rate_load <= wr_rate;
			dev_clear <= wr_rx_ctrl &&
			             io_wdata[`TERM_CTRL_DCLR_BIT];
		end
	end

	// ****************************************************************
	// Rates and interrupt lines
	// ****************************************************************
	// Registered so every pin comes from a flip-flop; costs one cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rx_baud       <= `TERM_BNONE;
			tx_baud       <= `TERM_BNONE;
			rx_rate_known <= 1'b0;
			tx_rate_known <= 1'b0;
			rx_int_req    <= 1'b0;
			tx_int_req    <= 1'b0;
		end else if (clk_en) begin
			rx_baud       <= baud_w[0];
			tx_baud       <= baud_w[1];
			rx_rate_known <= known_w[0];
			tx_rate_known <= known_w[1];
			rx_int_req    <= rx_req && !clr_rx;
			tx_int_req    <= tx_req && !clr_tx;
		end
	end

	// ****************************************************************
	// Identify cycle
	// ****************************************************************
	// The answer is frozen at the strobe and held until it drops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			id_state_r    <= term_pkg::ID_IDLE;
			reply         <= 1'b0;
			connect       <= 1'b0;
			ident_data    <= 8'h00;
			ident_data_oe <= 1'b0;
		end else if (clk_en) begin
			case (id_state_r)
				term_pkg::ID_IDLE: begin
					if (identify_strobe) begin
						id_state_r    <= term_pkg::ID_HOLD;
						reply         <= hit_req;
						connect       <= hit_req;
						ident_data_oe <= hit_req;
						ident_data    <= hit_req ? ident_code : 8'h00;
					end
				end
				term_pkg::ID_HOLD: begin
					if (!identify_strobe) begin
						id_state_r    <= term_pkg::ID_IDLE;
						reply         <= 1'b0;
						connect       <= 1'b0;
						ident_data_oe <= 1'b0;
						ident_data    <= 8'h00;
					end
				end
				default: begin
					id_state_r <= term_pkg::ID_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_both_rates_110: assert property (
		(wr_rate && clk_en && io_wdata[7:0] == 8'hCC) ##1 clk_en
		|=> rx_baud == `TERM_B110 && tx_baud == `TERM_B110)
		else $error("rate word 314 did not give 110 both ways");

	a_tx_code_map: assert property (
		(clk_en && rate_r[7:4] == 4'hD) |=> tx_baud == `TERM_B200)
		else $error("transmit code 1101 did not give 200 baud");

	a_rx_code_map: assert property (
		(wr_rate && clk_en && io_wdata[7:0] == 8'h0C) ##1 clk_en
		|=> rx_baud == `TERM_B110 && tx_baud == `TERM_B9600)
		else $error("rate word 14 gave wrong rates");

	a_request_and: assert property (
		clk_en |=> rx_int_req == ($past(rx_char_ready) &&
		           $past(rx_ie_r) && !$past(clr_rx)))
		else $error("receive request not ready and enable");

	a_enable_readback: assert property (
		(rd_tx_stat && clk_en)
		|=> io_rdata_valid && io_rdata[0] == $past(tx_ie_r))
		else $error("status bit 0 does not show the enable");

	a_ident_answer: assert property (
		(id_start && clk_en && sel_rx && rx_int_req)
		|=> reply && connect && ident_data_oe &&
		    ident_data == {1'b0, $past(ident_switch)})
		else $error("accepted identify gave no proper answer");

	a_answer_hold: assert property (
		(reply && identify_strobe && clk_en) |=> reply && connect)
		else $error("answer dropped while strobe high");

	a_enable_clear: assert property (
		(id_start && clk_en && sel_tx && tx_int_req && !wr_tx_ctrl)
		|=> !tx_ie_r && !tx_int_req)
		else $error("identify did not clear the enable");

	a_no_answer: assert property (
		(id_start && clk_en && !hit_req && !wr_rx_ctrl && !wr_tx_ctrl)
		|=> !reply && !connect && !ident_data_oe &&
		    $stable(rx_ie_r) && $stable(tx_ie_r))
		else $error("identify without request changed state");

	a_clear_keeps_rate: assert property (
		(dev_clear && clk_en) |-> $stable(rate_r))
		else $error("device clear changed the rates");

	c_rx_identify: cover property (
		id_start && clk_en && sel_rx && rx_int_req);
	c_tx_identify: cover property (
		id_start && clk_en && sel_tx && tx_int_req);
	c_empty_identify: cover property (
		id_start && clk_en && !hit_req);
	c_rate_write: cover property (wr_rate && clk_en);

endmodule // serial_term_rate_irq

// ### hw/term_map.svh
// Offsets, bit positions, reset values and rate constants of the terminal card
`ifndef TERM_MAP_SVH
`define TERM_MAP_SVH

// ********************************************************************
// Register offsets within the eight-address device group
// ********************************************************************
`define TERM_DEV_BASE    11'h0C0
`define TERM_OFS_RATE    3'h1
`define TERM_OFS_RX_STAT 3'h2
`define TERM_OFS_RX_CTRL 3'h3
`define TERM_OFS_TX_STAT 3'h6
`define TERM_OFS_TX_CTRL 3'h7

// ********************************************************************
// Field positions
// ********************************************************************
`define TERM_CTRL_IE_BIT   0
`define TERM_CTRL_DCLR_BIT 4
`define TERM_STAT_IE_BIT   0
`define TERM_STAT_RDY_BIT  3
`define TERM_RX_CODE_LSB   0
`define TERM_TX_CODE_LSB   4

// ********************************************************************
// Reset values and level codes on address bits 1..0
// ********************************************************************
`define TERM_RATE_RST   8'h00
`define TERM_LVL_RX     2'h2
`define TERM_LVL_TX     2'h0

// ********************************************************************
// Baud rates, as plain numbers of bits per second
// ********************************************************************
`define TERM_B9600 14'h2580
`define TERM_B4800 14'h12C0
`define TERM_B2400 14'h0960
`define TERM_B1200 14'h04B0
`define TERM_B600  14'h0258
`define TERM_B300  14'h012C
`define TERM_B200  14'h00C8
`define TERM_B150  14'h0096
`define TERM_B110  14'h006E
`define TERM_B100  14'h0064
`define TERM_B75   14'h004B
`define TERM_B50   14'h0032
`define TERM_BNONE 14'h0000

`endif

// ### hw/term_pkg.sv
// Types shared by the terminal rate and interrupt logic
package term_pkg;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef logic [13:0] baud_t;
	typedef logic [3:0]  rate_code_t;

	// Identify cycle sequencer, one-hot
	typedef enum logic [1:0] {
		ID_IDLE = 2'b01,
		ID_HOLD = 2'b10
	} id_state_t;

endpackage
